// >>> dual_adc_output_power_ctrl.sv
// output formatting, output buffers and power state control of a dual 12-bit converter
// Overview of operation
// - codes 000-011 select normal or buffer disables
// - 100 global down, 101/110 channel standby
// - 111 interleaves both channels onto bus B
// - three pins give code, first pin MSB
// - global down: converters, reference, buffers off
// - global down exit waits fifteen microseconds
// - standby keeps reference, resumes after 100 ns
// - disabled buffer tri-states, restores in 100 ns
// - sample clock under 1 MSPS: low power
// - twelve bits per channel, shared forwarded clock
// - interface type from bit or select pin
// - single-ended: all bits every sample cycle
// - DDR: two bits per pair, six pairs
// - even bits on rise, odd on fall
// - separate data and clock drive boosts
// - current default 3.5, else 2.5/4.5/1.75 mA
// - current double doubles programmed current
// - three termination enables, any combination
// - code format from bit or select pin
// - overdrive saturates to the fixed codes
// - multiplex only single-ended, bus A tri-stated
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module dual_adc_output_power_ctrl
    import adc_out_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // pins
    input wire logic sample_clk_in,
    input wire logic power_mode_pin_msb_in,
    input wire logic power_mode_pin_mid_in,
    input wire logic power_mode_pin_lsb_in,
    input wire logic interface_select_pin_in,
    // converter core
    input wire logic [adc_out_pkg::SAMPLE_W-1:0] adc_a_in,
    input wire logic [adc_out_pkg::SAMPLE_W-1:0] adc_b_in,
    input wire logic [1:0] ovr_pos_in,
    input wire logic [1:0] ovr_neg_in,
    output logic [1:0] adc_power_out,
    output logic ref_power_out,
    output logic low_power_out,
    // single-ended buses
    output logic [adc_out_pkg::SAMPLE_W-1:0] bus_a_pins_out,
    output logic bus_a_pins_oe_out,
    output logic [adc_out_pkg::SAMPLE_W-1:0] bus_b_pins_out,
    output logic bus_b_pins_oe_out,
    output logic forwarded_clock_out,
    output logic forwarded_clock_oe_out,
    // DDR pairs
    output logic [adc_out_pkg::PAIRS-1:0] ddr_a_out,
    output logic ddr_a_oe_out,
    output logic [adc_out_pkg::PAIRS-1:0] ddr_b_out,
    output logic ddr_b_oe_out,
    output logic forwarded_clock_pos_out,
    output logic forwarded_clock_pos_oe_out,
    // analog buffer settings
    output logic data_drive_level_out,
    output logic clock_drive_level_out,
    output logic [7:0] lvds_current_out,
    output logic [2:0] term_en_out
);
    import adc_out_pkg::*;

    // ==========
    // register bus
    logic [CONFIG_BITS-1:0] cfg;
    logic wr_pend;
    logic [7:0] dp_addr;
    logic [31:0] status;
    logic addr_ok;

    assign hreadyout_out = ce_in;
    assign hresp_out = 1'b0;
    assign addr_ok = hsel_in && htrans_in[1] && hready_in;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            wr_pend <= 1'b0;
            dp_addr <= 8'h00;
        end else if (ce_in) begin
            wr_pend <= addr_ok && hwrite_in && (hsize_in == 3'h2);
            if (addr_ok) begin
                dp_addr <= haddr_in[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            cfg <= CONFIG_RESET[CONFIG_BITS-1:0];
        end else if (ce_in && wr_pend && dp_addr == CONFIG_OFS) begin
            cfg <= hwdata_in[CONFIG_BITS-1:0];
        end
    end

    always_comb begin
        unique case (dp_addr)
            CONFIG_OFS: hrdata_out = {{(32-CONFIG_BITS){1'b0}}, cfg};
            STATUS_OFS: hrdata_out = status;
            default: hrdata_out = 32'h0000_0000;
        endcase
    end

    // ==========
    // pin synchronisers
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic clk_s3;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
            clk_s3 <= 1'b0;
        end else if (ce_in) begin
            pin_s1 <= {sample_clk_in, interface_select_pin_in, power_mode_pin_msb_in,
                       power_mode_pin_mid_in, power_mode_pin_lsb_in};
            pin_s2 <= pin_s1;
            clk_s3 <= pin_s2[4];
        end
    end

    logic s_rise;
    logic s_fall;
    assign s_rise = pin_s2[4] && !clk_s3;
    assign s_fall = !pin_s2[4] && clk_s3;

    // ==========
    // mode source and decode
    logic par_src;
    logic [2:0] pm;
    logic ddr;
    logic twos;
    logic pdn;
    logic mux;
    logic [1:0] stby;
    logic [1:0] bufoff;

    assign par_src = cfg[F_PAR];
    assign pm = par_src ? pin_s2[2:0] : cfg[F_PM+:3];
    assign ddr = par_src ? pin_s2[3] : cfg[F_DDR];
    assign twos = par_src ? pin_s2[3] : cfg[F_TWOS];
    assign pdn = pm == PM_PDN;
    assign stby[0] = pm == PM_STBY_A;
    assign stby[1] = pm == PM_STBY_B;
    assign bufoff[0] = pm == PM_BUF_A || pm == PM_BUF_AB;
    assign bufoff[1] = pm == PM_BUF_B || pm == PM_BUF_AB;
    assign mux = pm == PM_MUX && !ddr;

    // ==========
    // sample clock rate watch
    logic [7:0] idle_cnt;
    logic low_power;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            idle_cnt <= 8'h00;
            low_power <= 1'b0;
        end else if (ce_in) begin
            if (s_rise) begin
                idle_cnt <= 8'h00;
                low_power <= 1'b0;
            end else if (idle_cnt == 8'(SLOW_CYC - 1)) begin
                low_power <= 1'b1;
            end else begin
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end

    // ==========
    // per channel wake, format and launch
    logic [1:0][SAMPLE_W-1:0] raw;
    logic [1:0][SAMPLE_W-1:0] conv;
    logic [1:0][SAMPLE_W-1:0] word;
    logic [1:0][SAMPLE_W-1:0] bus_q;
    logic [1:0][PAIRS-1:0] ddr_q;
    logic [1:0][11:0] wake_cnt;
    logic [1:0] valid;
    logic [1:0] oe;
    logic fclk;

    assign raw[0] = adc_a_in;
    assign raw[1] = adc_b_in;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic off;
        assign off = pdn || stby[i] || low_power;
        assign valid[i] = wake_cnt[i] == 12'h000;
        // tri-state at once; the wake count only reloads on the next edge
        assign oe[i] = valid[i] && !off && !bufoff[i] && !(mux && i == 0);

        always_ff @(posedge ref_clk_in) begin
            if (!nrst_in) begin
                wake_cnt[i] <= 12'(PDN_WAKE_CYC);
            end else if (ce_in) begin
                if (pdn) begin
                    wake_cnt[i] <= 12'(PDN_WAKE_CYC);
                end else if (off || bufoff[i]) begin
                    wake_cnt[i] <= 12'(FAST_WAKE_CYC);
                end else if (!valid[i]) begin
                    wake_cnt[i] <= wake_cnt[i] - 12'h001;
                end
            end
        end

        always_comb begin
            if (ovr_pos_in[i]) begin
                conv[i] = twos ? SAT_POS_TWOS : SAT_POS_BIN;
            end else if (ovr_neg_in[i]) begin
                conv[i] = twos ? SAT_NEG_TWOS : SAT_NEG_BIN;
            end else begin
                conv[i] = raw[i] ^ {twos, {(SAMPLE_W-1){1'b0}}};
            end
        end

        always_ff @(posedge ref_clk_in) begin
            if (!nrst_in) begin
                word[i] <= '0;
                bus_q[i] <= '0;
                ddr_q[i] <= '0;
            end else if (ce_in && s_rise) begin
                word[i] <= conv[i];
                bus_q[i] <= (mux && i == 1) ? conv[0] : conv[i];
                for (int k = 0; k < PAIRS; k++) begin
                    ddr_q[i][k] <= conv[i][2*k];
                end
            end else if (ce_in && s_fall) begin
                if (mux && i == 1) begin
                    bus_q[i] <= word[1];
                end
                for (int k = 0; k < PAIRS; k++) begin
                    ddr_q[i][k] <= word[i][2*k+1];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            fclk <= 1'b0;
        end else if (ce_in && s_rise) begin
            fclk <= 1'b1;
        end else if (ce_in && s_fall) begin
            fclk <= 1'b0;
        end
    end

    // ==========
    // pins and analog controls
    assign bus_a_pins_out = bus_q[0];
    assign bus_b_pins_out = bus_q[1];
    assign bus_a_pins_oe_out = oe[0] && !ddr;
    assign bus_b_pins_oe_out = oe[1] && !ddr;
    assign ddr_a_out = ddr_q[0];
    assign ddr_b_out = ddr_q[1];
    assign ddr_a_oe_out = oe[0] && ddr;
    assign ddr_b_oe_out = oe[1] && ddr;
    assign forwarded_clock_out = fclk;
    assign forwarded_clock_pos_out = fclk;
    assign forwarded_clock_oe_out = !pdn && !ddr;
    assign forwarded_clock_pos_oe_out = !pdn && ddr;
    assign adc_power_out[0] = !(pdn || stby[0] || low_power);
    assign adc_power_out[1] = !(pdn || stby[1] || low_power);
    assign ref_power_out = !pdn;
    assign low_power_out = low_power;
    assign data_drive_level_out = cfg[F_DDRIVE];
    assign clock_drive_level_out = cfg[F_CDRIVE];
    assign term_en_out = cfg[F_TERM+:3];

    logic [7:0] cur_base;
    always_comb begin
        unique case (cfg[F_CUR+:2])
            2'h0: cur_base = CUR_3P5;
            2'h1: cur_base = CUR_2P5;
            2'h2: cur_base = CUR_4P5;
            2'h3: cur_base = CUR_1P75;
        endcase
    end
    assign lvds_current_out = cfg[F_DBL] ? {cur_base[6:0], 1'b0} : cur_base;

    assign status = {14'h0000, lvds_current_out, pdn, valid, low_power, mux, twos, ddr, pm};

    // ==========
    // elaboration checks
    // counters are sized for the documented figures; refuse figures they cannot hold
    if (PDN_WAKE_CYC > 4095 || FAST_WAKE_CYC < 1 || FAST_WAKE_CYC > PDN_WAKE_CYC) begin : g_bad_wake
        $error("wake counts do not fit the twelve bit wake counter");
    end
    if (SLOW_CYC < 2 || SLOW_CYC > 256) begin : g_bad_slow
        $error("slow clock limit does not fit the eight bit idle counter");
    end
    if (PAIRS * 2 != SAMPLE_W || SAMPLE_W != 12) begin : g_bad_width
        $error("sample width must be twelve bits split into pairs");
    end

    // ==========
    // checks
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_buf_a_off: assert property (pm == PM_BUF_A |-> !bus_a_pins_oe_out && !ddr_a_oe_out)
        else $error("bus A driven while its buffer is off");
    a_pdn_all_off: assert property (pdn |-> !oe[0] && !oe[1] && !ref_power_out && adc_power_out == 2'b00)
        else $error("something powered in global power down");
    a_stby_ref_on: assert property (stby[0] && !low_power |-> ref_power_out && !adc_power_out[0] && adc_power_out[1])
        else $error("standby A powers wrong parts");
    a_mux_bus_a: assert property (mux |-> !bus_a_pins_oe_out && pm == PM_MUX && !ddr)
        else $error("bus A driven in multiplexed mode");
    a_slow_wake: assert property (ce_in && $past(ce_in) && $fell(pdn) && !low_power && !stby[0] && !bufoff[0]
        |=> wake_cnt[0] == 12'(PDN_WAKE_CYC - 1))
        else $error("power down wake not started at full length");
    a_fast_wake: assert property (ce_in && bufoff[1] && !pdn && !low_power
        |=> !oe[1] && wake_cnt[1] == 12'(FAST_WAKE_CYC))
        else $error("buffer wake count wrong");
    a_slow_clock: assert property (ce_in && !s_rise && idle_cnt == 8'(SLOW_CYC - 1) |=> low_power_out)
        else $error("low power not entered on slow clock");
    a_sat_twos: assert property (ce_in && s_rise && ovr_pos_in[0] && twos |=> word[0] == SAT_POS_TWOS)
        else $error("positive overdrive code wrong");
    a_ddr_even: assert property (ce_in && s_rise |=> fclk && ddr_q[0][1] == word[0][2])
        else $error("even bits not launched with clock rise");
    a_ddr_odd: assert property (ce_in && s_fall |=> !fclk && ddr_q[1][0] == word[1][1])
        else $error("odd bits not launched with clock fall");
    a_par_source: assert property (par_src && $past(nrst_in) && $past(nrst_in, 2) && $past(ce_in)
        && $past(ce_in, 2) |-> pm == {$past(power_mode_pin_msb_in, 2), $past(power_mode_pin_mid_in, 2),
        $past(power_mode_pin_lsb_in, 2)})
        else $error("parallel power code not taken from pins");
    a_stby_tristate: assert property (stby[0] || low_power |-> !bus_a_pins_oe_out && !ddr_a_oe_out)
        else $error("standby or low power channel A still driven");
    a_ovr_neg: assert property (ce_in && s_rise && !ovr_pos_in[0] && ovr_neg_in[0] && !twos
        |=> word[0] == SAT_NEG_BIN)
        else $error("negative overdrive code wrong");
    a_word_hold: assert property (ce_in && !s_rise && !s_fall |=> $stable(bus_q[0]) && $stable(fclk))
        else $error("channel A word moved between sample edges");
    a_cur_double: assert property (cfg[F_DBL] && cfg[F_CUR+:2] == 2'h0
        |-> lvds_current_out == {CUR_3P5[6:0], 1'b0})
        else $error("doubled default current wrong");
    a_mux_b_fall: assert property (ce_in && s_fall && mux |=> bus_b_pins_out == word[1])
        else $error("channel B sample missing after clock fall in multiplexed mode");
    a_clock_oe: assert property (pdn |-> !forwarded_clock_oe_out && !forwarded_clock_pos_oe_out)
        else $error("output clock driven in global power down");
    a_wake_down: assert property (ce_in && !valid[0] && !pdn && !stby[0] && !low_power && !bufoff[0]
        |=> wake_cnt[0] == $past(wake_cnt[0]) - 12'h001)
        else $error("wake count not running down");
    a_slow_exit: assert property (ce_in && s_rise |=> !low_power_out)
        else $error("low power kept after a sample clock rise");
    a_ce_freeze: assert property (!ce_in |=> $stable(cfg) && $stable(wake_cnt) && $stable(fclk))
        else $error("state moved while clock enable low");

    c_mux_run: cover property (mux && s_fall);
    c_pdn_wake: cover property ($fell(pdn) ##[1:20] !pdn);
    c_ddr_out: cover property (ddr_a_oe_out && s_rise);
    c_low_power: cover property ($rose(low_power));
    c_stby_wake: cover property ($fell(stby[0]));
endmodule

// >>> adc_out_pkg.sv
// constants for the dual converter output and power control block
package adc_out_pkg;
    // ==========
    // data path
    localparam int SAMPLE_W = 12;
    localparam int PAIRS = SAMPLE_W / 2;
    localparam logic [11:0] SAT_POS_BIN = 12'h7FF;
    localparam logic [11:0] SAT_POS_TWOS = 12'h3FF;
    localparam logic [11:0] SAT_NEG_BIN = 12'h000;
    localparam logic [11:0] SAT_NEG_TWOS = 12'h400;
    // ==========
    // power state codes
    localparam logic [2:0] PM_NORMAL = 3'h0;
    localparam logic [2:0] PM_BUF_A = 3'h1;
    localparam logic [2:0] PM_BUF_B = 3'h2;
    localparam logic [2:0] PM_BUF_AB = 3'h3;
    localparam logic [2:0] PM_PDN = 3'h4;
    localparam logic [2:0] PM_STBY_A = 3'h5;
    localparam logic [2:0] PM_STBY_B = 3'h6;
    localparam logic [2:0] PM_MUX = 3'h7;
    // ==========
    // timing
    localparam int CLK_MHZ = 200;
    localparam int PDN_WAKE_US = 15;
    localparam int FAST_WAKE_NS = 100;
    localparam int SLOW_PERIOD_NS = 1000;
    localparam int PDN_WAKE_CYC = PDN_WAKE_US * CLK_MHZ;
    localparam int FAST_WAKE_CYC = (FAST_WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int SLOW_CYC = (SLOW_PERIOD_NS * CLK_MHZ) / 1000;
    // ==========
    // registers
    localparam logic [7:0] CONFIG_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int F_PM = 0;
    localparam int F_DDR = 3;
    localparam int F_TWOS = 4;
    localparam int F_PAR = 5;
    localparam int F_DDRIVE = 6;
    localparam int F_CDRIVE = 7;
    localparam int F_CUR = 8;
    localparam int F_DBL = 10;
    localparam int F_TERM = 11;
    localparam int CONFIG_BITS = 14;
    // differential current in quarter milliamps, by code
    localparam logic [7:0] CUR_3P5 = 8'h0E;
    localparam logic [7:0] CUR_2P5 = 8'h0A;
    localparam logic [7:0] CUR_4P5 = 8'h12;
    localparam logic [7:0] CUR_1P75 = 8'h07;
endpackage

// >>> capture_rx.sv
// capture receiver model latching converter output words
`timescale 1ns/1ps
module capture_rx (
    // clock and link
    input wire logic clk_in,
    input wire logic fclk_in,
    input wire logic [11:0] bus_a_in,
    input wire logic [11:0] bus_b_in,
    input wire logic [5:0] ddr_a_in,
    input wire logic [5:0] ddr_b_in,
    // captured words
    output logic [11:0] cap_a_out,
    output logic [11:0] cap_b_out,
    output logic [11:0] cap_bf_out,
    output logic [11:0] cap_ddr_out,
    output logic [11:0] cap_ddr_b_out
);
    logic fclk_q;
    logic [5:0] even_q;
    logic [5:0] even_b_q;
    always_ff @(posedge clk_in) begin
        fclk_q <= fclk_in;
        if (fclk_in && !fclk_q) begin
            cap_a_out <= bus_a_in;
            cap_b_out <= bus_b_in;
            even_q <= ddr_a_in;
            even_b_q <= ddr_b_in;
        end
        if (!fclk_in && fclk_q) begin
            cap_bf_out <= bus_b_in;
            for (int k = 0; k < 6; k++) begin
                cap_ddr_out[2*k] <= even_q[k];
                cap_ddr_out[2*k+1] <= ddr_a_in[k];
                cap_ddr_b_out[2*k] <= even_b_q[k];
                cap_ddr_b_out[2*k+1] <= ddr_b_in[k];
            end
        end
    end
endmodule

// >>> dual_adc_output_power_ctrl_tb_top.sv
// self-checking bench for the converter output and power control block
`timescale 1ns/1ps
module dual_adc_output_power_ctrl_tb_top;
    import adc_out_pkg::*;
    // ==========
    // stimulus and observed signals
    logic clk = 0, nrst = 0, sclk = 0, srun = 1, ce = 1, pc;
    logic hsel = 0, hwrite = 0, isel = 0;
    logic [1:0] htrans = 0, ovr_p = 0, ovr_n = 0, adc_pw;
    logic [2:0] hsize = 3'h2, pm = 0, term;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [11:0] adc_a = 12'h123, adc_b = 12'h456, ba, bb, pa, pb, ca, cb, cbf, cd, cdb;
    logic [5:0] da, db, pd, pdb;
    logic [7:0] cur;
    logic hready, hresp, ref_pw, lowp, ba_oe, bb_oe, fclk, fclk_oe, da_oe, db_oe, fp, fp_oe, ddrv, cdrv;
    int miscompares = 0, check_count = 0;
    localparam logic [11:0] SAT [4] = '{SAT_POS_BIN, SAT_POS_TWOS, SAT_NEG_BIN, SAT_NEG_TWOS};
    localparam logic [1:0] OE_EXP [8] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1};
    localparam logic [2:0] PW_EXP [8] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h0, 3'h6, 3'h5, 3'h7};
    localparam logic [7:0] CUR_EXP [4] = '{CUR_3P5, CUR_2P5, CUR_4P5, CUR_1P75};
    always #2.5 clk = ~clk;
    always #32 if (srun) sclk = ~sclk;
    // released pins show the inverse of their last value
    assign pa = ba_oe ? ba : ~ba;
    assign pb = bb_oe ? bb : ~bb;
    assign pd = da_oe ? da : ~da;
    assign pdb = db_oe ? db : ~db;
    // receiver follows whichever output clock is driven
    assign pc = fp_oe ? fp : fclk;
    dual_adc_output_power_ctrl DUT (
        .ref_clk_in(clk), .nrst_in(nrst), .ce_in(ce),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .sample_clk_in(sclk),
        .power_mode_pin_msb_in(pm[2]), .power_mode_pin_mid_in(pm[1]), .power_mode_pin_lsb_in(pm[0]),
        .interface_select_pin_in(isel), .adc_a_in(adc_a), .adc_b_in(adc_b),
        .ovr_pos_in(ovr_p), .ovr_neg_in(ovr_n), .adc_power_out(adc_pw), .ref_power_out(ref_pw),
        .low_power_out(lowp), .bus_a_pins_out(ba), .bus_a_pins_oe_out(ba_oe),
        .bus_b_pins_out(bb), .bus_b_pins_oe_out(bb_oe), .forwarded_clock_out(fclk),
        .forwarded_clock_oe_out(fclk_oe), .ddr_a_out(da), .ddr_a_oe_out(da_oe),
        .ddr_b_out(db), .ddr_b_oe_out(db_oe), .forwarded_clock_pos_out(fp),
        .forwarded_clock_pos_oe_out(fp_oe), .data_drive_level_out(ddrv),
        .clock_drive_level_out(cdrv), .lvds_current_out(cur), .term_en_out(term)
    );
    capture_rx rx (
        .clk_in(clk), .fclk_in(pc), .bus_a_in(pa), .bus_b_in(pb), .ddr_a_in(pd), .ddr_b_in(pdb),
        .cap_a_out(ca), .cap_b_out(cb), .cap_bf_out(cbf), .cap_ddr_out(cd), .cap_ddr_b_out(cdb)
    );
    // ==========
    // bus tasks and checks
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        cyc(40000);
        miscompares++;
        stop_test();
    end
    // ==========
    // test sequence
    initial begin
        cyc(12);
        nrst <= 1'b1;
        @(posedge clk);
        ahb(1'b0, 32'(CONFIG_OFS), 0, rd);
        chk("config reset", CONFIG_RESET, rd);
        wr(32'h10, 32'h3FFF);
        ahb(1'b0, 32'h10, 0, rd);
        chk("unmapped", 0, rd);
        ahb(1'b0, 32'(CONFIG_OFS), 0, rd);
        chk("config kept", 0, rd);
        chk("hresp", 0, 32'(hresp));
        cyc(3100);
        chk("normal oe", 3'h7, {ba_oe, bb_oe, fclk_oe});
        chk("word a", 12'h123, ca);
        chk("word b", 12'h456, cb);
        for (int i = 0; i < 4; i++) begin
            wr(32'(CONFIG_OFS), 32'(i[0]) << F_TWOS);
            ovr_p <= {1'b0, !i[1]};
            ovr_n <= {1'b0, i[1]};
            cyc(40);
            chk("saturated a", SAT[i], ca);
        end
        ovr_p <= 2'h0;
        ovr_n <= 2'h0;
        for (int i = 1; i < 7; i++) begin
            wr(32'(CONFIG_OFS), 32'(i));
            cyc(40);
            chk("mode oe", OE_EXP[i], {ba_oe, bb_oe});
            chk("mode power", PW_EXP[i], {ref_pw, adc_pw});
            wr(32'(CONFIG_OFS), 0);
            cyc(((i == 4) ? PDN_WAKE_CYC : FAST_WAKE_CYC) - 10);
            chk("oe waking", OE_EXP[i], {ba_oe, bb_oe});
            cyc(20);
            chk("oe awake", 2'h3, {ba_oe, bb_oe});
        end
        wr(32'(CONFIG_OFS), 32'(PM_MUX));
        cyc(40);
        chk("mux oe", 2'h1, {ba_oe, bb_oe});
        chk("mux rise", 12'h123, cb);
        chk("mux fall", 12'h456, cbf);
        wr(32'(CONFIG_OFS), 32'h1 << F_DDR);
        cyc(40);
        chk("ddr oe", 4'hD, {da_oe, db_oe, ba_oe, fp_oe});
        chk("ddr word", 12'h123, cd);
        chk("ddr word b", 12'h456, cdb);
        pm <= 3'h5;
        isel <= 1'b1;
        wr(32'(CONFIG_OFS), 32'h1 << F_PAR);
        cyc(8);
        ahb(1'b0, 32'(STATUS_OFS), 0, rd);
        chk("pin status", 32'h0000_391D, rd);
        chk("pin power", 2'h2, adc_pw);
        wr(32'(CONFIG_OFS), 0);
        cyc(8);
        ahb(1'b0, 32'(STATUS_OFS), 0, rd);
        chk("serial status", 5'h0, rd[4:0]);
        for (int i = 0; i < 8; i++) begin
            wr(32'(CONFIG_OFS), 32'((i << F_TERM) | ((i & 3) << F_CUR) | ((i >> 2) << F_DBL)
                | ((i & 1) << F_DDRIVE) | (((i >> 1) & 1) << F_CDRIVE)));
            @(posedge clk);
            chk("current", 32'(CUR_EXP[i & 3]) << (i >> 2), cur);
            chk("term drive", {i[2:0], i[0], i[1]}, {term, ddrv, cdrv});
        end
        wr(32'(CONFIG_OFS), 0);
        cyc(40);
        srun <= 1'b0;
        ce <= 1'b0;
        cyc(300);
        chk("frozen", 2'h0, {lowp, hready});
        ce <= 1'b1;
        cyc(300);
        chk("slow clock", 4'h8, {lowp, adc_pw, ba_oe});
        srun <= 1'b1;
        cyc(60);
        chk("clock back", 4'h7, {lowp, adc_pw, ba_oe});
        stop_test();
    end
endmodule
